// ### rtl/rpmc_top.v
// Purpose: Reset combining, reset cause, boot vector and power modes
// Assumes: arst_n is the power-on detect; other sources are live
// Notes:   Pins are resynchronised; wdt and break pulses are local
//          Control writes are ignored while the power-up phase runs
//          Boot choice is recomputed at every reset
//
// Overview of operation
// - Brownout resets by default, else interrupts
// - Software enables brownout; disabled gives nothing
// - Power-on flag set at power-up, software clears
// - Three low-power states: idle, pd, total pd
// - Idle keeps peripherals; irq or reset exits
// - Power-down stops oscillator; reset or wake exits
// - Bod, wdt, comparators, rtc run in power-down
// - RC oscillator off unless selected with rtc
// - Total power-down also stops bod and comparators
// - Enable bit selects reset or digital pin
// - Power-up forces pin as reset input
// - Six reset sources combined into reset
// - One readable cause flag per source
// - Writing zero clears flag; several may stand
// - Power-on sets pof and bof, clears rest
// - Other resets set own flag, keep others
// - Vector is zero or boot byte with 00h
// - Boot on break, boot status, forced isp
// - Enabled external interrupt wakes from sleep
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "rpmc_defs.vh"
module rpmc_top #(
    parameter POR_HOLD_CYCLES  = `RPMC_POR_HOLD,
    parameter RST_PULSE_CYCLES = `RPMC_RST_PULSE
) (
    input  wire                    clk_sys,
    input  wire                    arst_n,
    input  wire [`RPMC_ADDR_W-1:0] reg_addr,
    input  wire [7:0]              reg_wdata,
    input  wire                    reg_wr,
    input  wire                    reg_rd,
    output reg  [7:0]              reg_rdata,
    input  wire                    shared_reset_pin,
    input  wire                    brownout_det,
    input  wire                    isp_force_pin,
    input  wire                    wdt_timeout,
    input  wire                    uart_break_det,
    input  wire                    reset_pin_enable,
    input  wire                    brownout_enable_fuse,
    input  wire [7:0]              boot_status_byte,
    input  wire [7:0]              boot_vector,
    input  wire                    irq_pending,
    input  wire                    pd_wake_irq,
    input  wire                    rc_osc_selected,
    input  wire                    rtc_enabled,
    output reg                     sys_reset,
    output reg                     brownout_irq,
    output reg                     pin_digital_in,
    output reg  [15:0]             reset_vector,
    output reg                     cpu_clk_en,
    output reg                     periph_clk_en,
    output reg                     main_osc_en,
    output reg                     rc_osc_en,
    output reg                     bod_power_en,
    output reg                     cmp_power_en,
    output reg  [1:0]              power_mode
);

    // Counts wider than the counter are cut on purpose
    localparam [`RPMC_CNT_W-1:0] POR_LOAD =
        POR_HOLD_CYCLES[`RPMC_CNT_W-1:0];
    localparam [`RPMC_CNT_W-1:0] RST_LOAD =
        RST_PULSE_CYCLES[`RPMC_CNT_W-1:0];

    // Async inputs: 0 pin, 1 brownout, 2 isp strap
    wire [2:0] async_in;
    reg  [2:0] sync1_reg;
    reg  [2:0] sync2_reg;
    reg  [2:0] sync3_reg;
    reg  [2:0] level_reg;

    assign async_in = {isp_force_pin, brownout_det, shared_reset_pin};

    // Pin rests high, brownout and isp low, so a quiet pin never looks like reset
    // Third stage lets a change count only once two stages agree
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            localparam [0:0] REST = (gi == 0) ? 1'b1 : 1'b0;
            always @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    sync1_reg[gi] <= REST;
                    sync2_reg[gi] <= REST;
                    sync3_reg[gi] <= REST;
                    level_reg[gi] <= REST;
                end else begin
                    sync1_reg[gi] <= async_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                    sync3_reg[gi] <= sync2_reg[gi];
                    if (sync2_reg[gi] == sync3_reg[gi]) begin
                        level_reg[gi] <= sync3_reg[gi];
                    end
                end
            end
        end
    endgenerate

    wire pin_level = level_reg[0];
    wire bo_level  = level_reg[1];
    wire isp_level = level_reg[2];

    // Power-up phase
    reg                   por_active_reg;
    reg [`RPMC_CNT_W-1:0] por_cnt_reg;

    // Control state
    reg [7:0]             cause_reg;
    reg                   bod_en_reg;
    reg                   bod_irq_reg;
    reg                   cmp_pd_reg;
    reg [1:0]             mode_reg;
    reg [1:0]             mode_next;
    reg                   sw_req_reg;
    reg                   boot_sel_reg;
    reg [`RPMC_CNT_W-1:0] rst_cnt_reg;

    // Pin role: forced to reset during power-up
    wire pin_is_reset = por_active_reg | reset_pin_enable;

    // Brownout only counts while enabled and powered
    wire bo_eff = bo_level & bod_en_reg
                & (mode_reg != `RPMC_MODE_TPD);

    // Reset sources outside power-up
    wire src_ext  = ~por_active_reg & reset_pin_enable
                  & ~pin_level;
    wire src_bo   = ~por_active_reg & bo_eff & ~bod_irq_reg;
    wire src_wdt  = ~por_active_reg & wdt_timeout;
    wire src_sw   = ~por_active_reg & sw_req_reg;
    wire src_ubrk = ~por_active_reg & uart_break_det;
    wire src_any  = src_ext | src_bo | src_wdt
                  | src_sw | src_ubrk;

    wire wr_cause = reg_wr & (reg_addr == `RPMC_OFS_CAUSE);
    wire wr_ctrl  = reg_wr & (reg_addr == `RPMC_OFS_CTRL);
    wire wr_swrst = reg_wr & (reg_addr == `RPMC_OFS_SWRST);

    wire [1:0] wr_mode =
        reg_wdata[`RPMC_CT_MODE_HI:`RPMC_CT_MODE_LO];

    // Stretch still running; holds run mode and reset
    wire rst_busy = (rst_cnt_reg != {`RPMC_CNT_W{1'b0}});

    // Power-up hold; a low pin keeps reloading the count
    // Power-up ends only after the pin stays high long enough
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            por_active_reg <= 1'b1;
            por_cnt_reg    <= POR_LOAD;
        end else if (por_active_reg) begin
            if (!pin_level) begin
                por_cnt_reg <= POR_LOAD;
            end else if (por_cnt_reg != {`RPMC_CNT_W{1'b0}}) begin
                por_cnt_reg <= por_cnt_reg - 1'b1;
            end else begin
                por_active_reg <= 1'b0;
            end
        end
    end

    // Reset cause flags; a new event wins over a clearing write
    // Power-on value comes only from arst_n
    reg [7:0] cause_set;
    reg [7:0] cause_next;
    always @* begin
        cause_set = 8'h00;
        cause_set[`RPMC_RC_EXT]  = src_ext;
        cause_set[`RPMC_RC_SW]   = src_sw;
        cause_set[`RPMC_RC_WDT]  = src_wdt;
        cause_set[`RPMC_RC_BOF]  = src_bo;
        cause_set[`RPMC_RC_UBRK] = src_ubrk;
        cause_next = cause_reg;
        if (wr_cause) begin
            cause_next = cause_reg & reg_wdata;
        end
        cause_next = cause_next | cause_set;
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cause_reg <= `RPMC_RC_RESET;
        end else begin
            cause_reg <= cause_next;
        end
    end

    // Control bits; fuse default is caught while power-up runs
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bod_en_reg  <= 1'b0;
            bod_irq_reg <= 1'b0;
            cmp_pd_reg  <= 1'b0;
            sw_req_reg  <= 1'b0;
        end else begin
            // Request lasts one cycle; the stretch does the rest
            sw_req_reg <= wr_swrst & reg_wdata[`RPMC_SW_GO];
            if (por_active_reg) begin
                bod_en_reg  <= brownout_enable_fuse;
                bod_irq_reg <= 1'b0;
            end else if (wr_ctrl) begin
                bod_en_reg  <= reg_wdata[`RPMC_CT_BOD_EN];
                bod_irq_reg <= reg_wdata[`RPMC_CT_BOD_IRQ];
                cmp_pd_reg  <= reg_wdata[`RPMC_CT_CMP_PD];
            end
        end
    end

    // Power mode sequencing; any reset beats a mode write, and wakes are only seen outside run
    always @* begin
        mode_next = mode_reg;
        // Mode writes are only taken from run
        case (mode_reg)
            `RPMC_MODE_RUN: begin
                if (wr_ctrl && wr_mode != `RPMC_MODE_RUN) begin
                    mode_next = wr_mode;
                end
            end
            `RPMC_MODE_IDLE: begin
                if (irq_pending) begin
                    mode_next = `RPMC_MODE_RUN;
                end
            end
            default: begin
                if (pd_wake_irq) begin
                    mode_next = `RPMC_MODE_RUN;
                end
            end
        endcase
        if (src_any || por_active_reg || rst_busy) begin
            mode_next = `RPMC_MODE_RUN;
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_reg <= `RPMC_MODE_RUN;
        end else begin
            mode_reg <= mode_next;
        end
    end

    // Reset stretch and boot choice
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_cnt_reg  <= {`RPMC_CNT_W{1'b0}};
            boot_sel_reg <= 1'b0;
        end else begin
            // Counter reloads while any source stays active
            if (src_any) begin
                rst_cnt_reg <= RST_LOAD;
            end else if (rst_cnt_reg != {`RPMC_CNT_W{1'b0}}) begin
                rst_cnt_reg <= rst_cnt_reg - 1'b1;
            end
            // Boot choice latched at each reset for the fetch
            if (por_active_reg) begin
                boot_sel_reg <= isp_level | boot_status_byte[0];
            end else if (src_any) begin
                boot_sel_reg <= src_ubrk | boot_status_byte[0];
            end
        end
    end

    // Outputs, all registered
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sys_reset      <= 1'b1;
            brownout_irq   <= 1'b0;
            pin_digital_in <= 1'b1;
            reset_vector   <= `RPMC_VEC_ZERO;
            cpu_clk_en     <= 1'b0;
            periph_clk_en  <= 1'b0;
            main_osc_en    <= 1'b1;
            rc_osc_en      <= 1'b1;
            bod_power_en   <= 1'b0;
            cmp_power_en   <= 1'b0;
            power_mode     <= `RPMC_MODE_RUN;
        end else begin
            sys_reset <= por_active_reg | src_any | rst_busy;
            // Level while brownout lasts; nothing latched here
            brownout_irq <= bo_eff & bod_irq_reg;
            // Reads high while the pin serves as reset
            pin_digital_in <= pin_is_reset | pin_level;
            reset_vector <= boot_sel_reg ?
                {boot_vector, `RPMC_VEC_LOW} : `RPMC_VEC_ZERO;
            // Gates follow mode_next so they move with power_mode
            cpu_clk_en    <= (mode_next == `RPMC_MODE_RUN);
            periph_clk_en <= (mode_next == `RPMC_MODE_RUN)
                           | (mode_next == `RPMC_MODE_IDLE);
            main_osc_en   <= ~mode_next[1];
            rc_osc_en     <= ~mode_next[1]
                           | (rc_osc_selected & rtc_enabled);
            // Watchdog and rtc are never gated here
            bod_power_en  <= bod_en_reg
                           & (mode_next != `RPMC_MODE_TPD);
            cmp_power_en  <= ~cmp_pd_reg
                           & (mode_next != `RPMC_MODE_TPD);
            power_mode    <= mode_next;
        end
    end

    // Read port; data valid only in the cycle after the strobe
    // Unmapped and write-only indexes read as zero
    reg [7:0] rd_mux;
    always @* begin
        rd_mux = 8'h00;
        if (reg_addr == `RPMC_OFS_CAUSE) begin
            rd_mux = cause_reg;
        end else if (reg_addr == `RPMC_OFS_CTRL) begin
            rd_mux[`RPMC_CT_BOD_EN]  = bod_en_reg;
            rd_mux[`RPMC_CT_BOD_IRQ] = bod_irq_reg;
            rd_mux[`RPMC_CT_MODE_HI:`RPMC_CT_MODE_LO] = mode_reg;
            rd_mux[`RPMC_CT_CMP_PD]  = cmp_pd_reg;
        end else if (reg_addr == `RPMC_OFS_STATUS) begin
            // Live status; pin and brownout after filtering
            rd_mux[`RPMC_ST_BO]   = bo_level;
            rd_mux[`RPMC_ST_PIN]  = pin_level;
            rd_mux[`RPMC_ST_BOOT] = boot_sel_reg;
            rd_mux[`RPMC_ST_POR]  = por_active_reg;
        end
    end

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

endmodule

// ### inc/rpmc_defs.vh
// Purpose: Constants for the reset and power mode control block
// Assumes: Byte-wide register port, 4-bit register index
// Notes:   Offsets are register indexes on the plain port
`ifndef RPMC_DEFS_VH
`define RPMC_DEFS_VH

// Register indexes
`define RPMC_ADDR_W        4
`define RPMC_OFS_CAUSE     4'h0
`define RPMC_OFS_CTRL      4'h1
`define RPMC_OFS_SWRST     4'h2
`define RPMC_OFS_STATUS    4'h3

// Reset cause flag positions
`define RPMC_RC_EXT        0
`define RPMC_RC_SW         1
`define RPMC_RC_WDT        2
`define RPMC_RC_BOF        3
`define RPMC_RC_UBRK       4
`define RPMC_RC_POF        5
`define RPMC_RC_RESET      8'h28

// Control register fields
`define RPMC_CT_BOD_EN     0
`define RPMC_CT_BOD_IRQ    1
`define RPMC_CT_MODE_LO    2
`define RPMC_CT_MODE_HI    3
`define RPMC_CT_CMP_PD     4

// Software reset request bit
`define RPMC_SW_GO         0

// Status register fields
`define RPMC_ST_BO         0
`define RPMC_ST_PIN        1
`define RPMC_ST_BOOT       2
`define RPMC_ST_POR        3

// Power modes
`define RPMC_MODE_RUN      2'h0
`define RPMC_MODE_IDLE     2'h1
`define RPMC_MODE_PD       2'h2
`define RPMC_MODE_TPD      2'h3

// Timing counts in clk_sys cycles
`define RPMC_POR_HOLD      16
`define RPMC_RST_PULSE     8
`define RPMC_CNT_W         8

// Reset vector parts
`define RPMC_VEC_ZERO      16'h0000
`define RPMC_VEC_LOW       8'h00

`endif

// ### sim/rpmc_props.sv
// Purpose: Port assertions for rpmc_top
// Assumes: One clock, arst_n is the only reset
// Notes:   Bound onto every rpmc_top
`timescale 1ns/1ps
`include "rpmc_defs.vh"
module rpmc_props (
    input wire       clk_sys,
    input wire       arst_n,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       shared_reset_pin,
    input wire       reset_pin_enable,
    input wire       irq_pending,
    input wire       pd_wake_irq,
    input wire       rc_osc_selected,
    input wire       rtc_enabled,
    input wire       sys_reset,
    input wire       main_osc_en,
    input wire       periph_clk_en,
    input wire       rc_osc_en,
    input wire       bod_power_en,
    input wire       cmp_power_en,
    input wire [1:0] power_mode
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    chk_pd_entry: assert property (reg_wr && reg_addr == `RPMC_OFS_CTRL && !sys_reset
        && power_mode == `RPMC_MODE_RUN && reg_wdata[3:2] == `RPMC_MODE_PD
        |=> power_mode == `RPMC_MODE_PD && !main_osc_en) else $error("no power-down entry");
    chk_pd_osc: assert property (power_mode == `RPMC_MODE_PD |-> !main_osc_en && !periph_clk_en)
        else $error("clock running in power-down");
    chk_idle_clk: assert property (power_mode == `RPMC_MODE_IDLE |-> periph_clk_en && main_osc_en)
        else $error("peripherals stopped in idle");
    chk_tpd_power: assert property (power_mode == `RPMC_MODE_TPD |-> !bod_power_en && !cmp_power_en)
        else $error("monitors powered in total power-down");
    chk_rc_keep: assert property (power_mode[1] |->
        rc_osc_en == ($past(rc_osc_selected) && $past(rtc_enabled))) else $error("rc oscillator wrong");
    chk_pd_wake: assert property (power_mode[1] && pd_wake_irq |=> power_mode == `RPMC_MODE_RUN)
        else $error("no wake from power-down");
    chk_idle_wake: assert property (power_mode == `RPMC_MODE_IDLE && irq_pending
        |=> power_mode == `RPMC_MODE_RUN) else $error("no wake from idle");
    // Sync and filter delay the pin by a few cycles
    chk_pin_reset: assert property ((reset_pin_enable && !shared_reset_pin) [*6]
        |-> ##[0:4] sys_reset) else $error("pin reset missed");
    chk_sw_reset: assert property (reg_wr && reg_addr == `RPMC_OFS_SWRST && reg_wdata[0]
        |-> ##[1:3] sys_reset) else $error("software reset missed");
    cov_pd: cover property (power_mode == `RPMC_MODE_PD);
    cov_tpd: cover property (power_mode == `RPMC_MODE_TPD);
    cov_rst: cover property ($rose(sys_reset));
endmodule

bind rpmc_top rpmc_props i_props (.*);

// ### sim/rpmc_supply_model.sv
// Purpose: External reset circuit and supply monitors
// Assumes: Bench requests arrive on clk_sys
// Notes:   Pin has a pull-up, so it idles high
`timescale 1ns/1ps
module rpmc_supply_model (
    input  wire  clk_sys,
    input  wire  arst_n,
    input  wire  pin_low_req,
    input  wire  bo_req,
    output logic shared_reset_pin,
    output logic brownout_det,
    output wire  isp_force_pin
);
    // No forced programming entry here
    assign isp_force_pin = 1'b0;
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shared_reset_pin <= 1'b1;
            brownout_det     <= 1'b0;
        end else begin
            shared_reset_pin <= !pin_low_req;
            brownout_det     <= bo_req;
        end
    end
endmodule

// ### sim/rpmc_tb_top.sv
// Purpose: Self-checking bench for rpmc_top
// Assumes: Short power-up and pulse counts
// Notes:   Expectations come from bench functions
`timescale 1ns/1ps
`include "rpmc_defs.vh"
module rpmc_tb_top;
    logic        clk_sys, arst_n, reg_wr, reg_rd, wdt_timeout, uart_break_det;
    logic        reset_pin_enable, brownout_enable_fuse, irq_pending, pd_wake_irq;
    logic        rc_osc_selected, rtc_enabled, pin_low_req, bo_req;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, boot_status_byte, boot_vector, lfsr, exp_cause;
    wire  [7:0]  reg_rdata;
    wire  [15:0] reset_vector;
    wire  [1:0]  power_mode;
    wire         shared_reset_pin, brownout_det, isp_force_pin, sys_reset, brownout_irq;
    wire         pin_digital_in, cpu_clk_en, periph_clk_en, main_osc_en, rc_osc_en;
    wire         bod_power_en, cmp_power_en;
    int          miscompares, cmp_count, cycles, m;

    // Short counts keep the run brief
    rpmc_top #(.POR_HOLD_CYCLES(4), .RST_PULSE_CYCLES(2)) i_dut (.*);
    rpmc_supply_model i_model (.*);

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            final_report;
        end
    end

    function automatic [7:0] lfsr_next(input [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic [15:0] exp_vec(input bsel, input [7:0] bv);
        return bsel ? {bv, `RPMC_VEC_LOW} : `RPMC_VEC_ZERO;
    endfunction

    task cmp(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task wr(input [3:0] a, input [7:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task rd(input [3:0] a, input [7:0] e);
        @(posedge clk_sys);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 cmp(reg_rdata, e);
    endtask

    // Bounded wait for a reset pulse to start and end
    task wait_rst;
        int i;
        for (i = 0; i < 20 && sys_reset !== 1'b1; i++) @(negedge clk_sys);
        for (i = 0; i < 200 && sys_reset !== 1'b0; i++) @(negedge clk_sys);
    endtask

    task final_report;
        if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        {arst_n, reg_wr, reg_rd, wdt_timeout, uart_break_det, irq_pending} = '0;
        {pd_wake_irq, pin_low_req, bo_req, reset_pin_enable, rtc_enabled} = '0;
        {brownout_enable_fuse, rc_osc_selected} = 2'b11;
        {reg_addr, reg_wdata, boot_status_byte, boot_vector} = '0;
        lfsr = 8'h1c;
        exp_cause = `RPMC_RC_RESET;
        repeat (4) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(`RPMC_OFS_CAUSE, exp_cause);
        wait_rst;
        wr(`RPMC_OFS_SWRST, 8'h01);
        wait_rst;
        exp_cause[`RPMC_RC_SW] = 1'b1;
        rd(`RPMC_OFS_CAUSE, exp_cause);
        cmp(reset_vector, exp_vec(1'b0, boot_vector));
        for (m = 0; m < 4; m++) begin
            lfsr = lfsr_next(lfsr);
            wr(`RPMC_OFS_CAUSE, m == 3 ? 8'h00 : lfsr);
            exp_cause = m == 3 ? 8'h00 : exp_cause & lfsr;
            rd(`RPMC_OFS_CAUSE, exp_cause);
        end
        // Watchdog with boot status, then break alone
        for (m = 0; m < 2; m++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk_sys);
            boot_status_byte <= {7'h00, m == 0};
            boot_vector <= lfsr;
            wdt_timeout <= (m == 0);
            uart_break_det <= (m == 1);
            @(posedge clk_sys);
            {wdt_timeout, uart_break_det} <= 2'b00;
            wait_rst;
            exp_cause[m == 0 ? `RPMC_RC_WDT : `RPMC_RC_UBRK] = 1'b1;
            rd(`RPMC_OFS_CAUSE, exp_cause);
            cmp(reset_vector, exp_vec(1'b1, lfsr));
            rd(`RPMC_OFS_STATUS, 8'h06);
        end
        for (m = 0; m < 2; m++) begin
            @(posedge clk_sys);
            reset_pin_enable <= m[0];
            pin_low_req <= 1'b1;
            repeat (8) @(posedge clk_sys);
            #1 cmp(sys_reset, m[0]);
            if (m == 0) cmp(pin_digital_in, 1'b0);
            @(posedge clk_sys);
            pin_low_req <= 1'b0;
        end
        wait_rst;
        exp_cause[`RPMC_RC_EXT] = 1'b1;
        rd(`RPMC_OFS_CAUSE, exp_cause);
        // Interrupt mode, disabled, then reset mode
        for (m = 0; m < 3; m++) begin
            wr(`RPMC_OFS_CTRL, m == 0 ? 8'h03 : (m == 1 ? 8'h00 : 8'h01));
            bo_req <= 1'b1;
            repeat (8) @(posedge clk_sys);
            #1 cmp(brownout_irq, m == 0);
            cmp(sys_reset, m == 2);
            @(posedge clk_sys);
            bo_req <= 1'b0;
        end
        wait_rst;
        exp_cause[`RPMC_RC_BOF] = 1'b1;
        rd(`RPMC_OFS_CAUSE, exp_cause);
        rd(`RPMC_OFS_CTRL, 8'h01);
        for (m = 1; m < 4; m++) begin
            rtc_enabled <= (m != 3);
            wr(`RPMC_OFS_CTRL, {3'h0, m == 2, m[1:0], 2'b01});
            #1 cmp(power_mode, m[1:0]);
            cmp(main_osc_en, m == 1);
            cmp(rc_osc_en, m != 3);
            cmp(bod_power_en, m != 3);
            cmp(periph_clk_en, m == 1);
            cmp(cpu_clk_en, 1'b0);
            @(posedge clk_sys);
            if (m == 1) irq_pending <= 1'b1;
            else pd_wake_irq <= 1'b1;
            #1 cmp(cmp_power_en, m == 1);
            repeat (2) @(posedge clk_sys);
            #1 cmp(power_mode, `RPMC_MODE_RUN);
            cmp(cpu_clk_en, 1'b1);
            @(posedge clk_sys);
            {irq_pending, pd_wake_irq} <= 2'b00;
        end
        final_report;
    end
endmodule
